// ===== hdl/usb_bufside_defines.svh
// Register offsets, field positions, reset values for the buffer-side and interrupt-enable block
`ifndef USB_BUFSIDE_DEFINES_SVH
`define USB_BUFSIDE_DEFINES_SVH
`define OFS_ENG_CTRL     8'h00
`define OFS_DMA_CTRL     8'h04
`define OFS_TRN_CNT      8'h08
`define OFS_INT_EN0      8'h30
`define OFS_INT_STAT0    8'h34
`define BIT_TOGGLE       15
`define BIT_ENG_CLEAR    14
`define BIT_ENG_BUSY     13
`define BIT_TRN_EN       0
`define IRQ_LSB          8
`define IRQ_MSB          15
`define RST_INT_EN0      16'h0000
`define RST_TRN_CNT      16'h0000
`endif

// ===== hdl/usb_bufside_pkg.sv
// Types shared by the buffer-side and interrupt-enable block
`default_nettype none
package usb_bufside_pkg;
   typedef struct packed
   {
      logic [7:0]  addr;
      logic        write;
      logic [31:0] wdata;
   } apb_req_s;
   typedef logic [7:0] irq_vec_t;
endpackage
`default_nettype wire

// ===== hdl/usb_bufside_regs.sv
// APB register slice: buffer handover, transaction counter, interrupt enables
//
// Operation
// R1: Writing one to toggle hands the engine-side buffer to the CPU.
// R2: Software sets NAK and sees busy at zero before toggling.
// R3: Toggle acts only on receive-direction pipes.
// R4: Writing one to engine clear empties the engine-side buffer.
// R5: Software sets NAK and waits for busy zero before clearing.
// R6: Engine clear acts only on send-direction pipes.
// R7: Counter write programs DMA transactions; read returns a transaction count.
// R8: Counter runs only when the pipe reads from buffer memory.
// R9: Read gives running count if count enable is one, else programmed.
// R10: Enable bit 13 gates the frame refresh interrupt.
// R11: Enable bit 12 gates the device state interrupt.
// R12: Enable bit 11 gates the control stage interrupt.
// R13: Enable bit 9 gates the not-ready interrupt.
// R14: Bits 15, 14, 10, 8 gate VBUS, resume, empty, ready; reset zero.
// R15: An interrupt asserts only while its flag and enable are both set.
//
// Added by the designer: the APB register port.
`include "usb_bufside_defines.svh"
`default_nettype none
module usb_bufside_regs
(
   input  wire logic        I_REF_CLK,
   input  wire logic        I_RST_B,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   input  wire logic        I_PIPE_RX,
   input  wire logic        I_ENG_BUSY,
   input  wire logic        I_TRN_STEP,
   input  wire logic [7:0]  I_IRQ_EVT,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   output logic [31:0]      O_PRDATA,
   output logic             O_BUF_TOGGLE,
   output logic             O_ENG_CLEAR,
   output logic [7:0]       O_IRQ_SRC,
   output logic             O_IRQ
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   usb_bufside_pkg::apb_req_s req;
   logic                      setup;
   logic                      wr_take;

   assign req       = '{addr: I_PADDR, write: I_PWRITE, wdata: I_PWDATA};
   assign setup     = I_PSEL & ~I_PENABLE;
   // Writes take effect only at the edge that completes the access phase
   assign wr_take   = I_PSEL & I_PENABLE & O_PREADY & req.write;

   function automatic logic hit(input logic [7:0] a);
      hit = (a == `OFS_ENG_CTRL) || (a == `OFS_DMA_CTRL) || (a == `OFS_TRN_CNT)
         || (a == `OFS_INT_EN0) || (a == `OFS_INT_STAT0);
   endfunction

   function automatic logic wr_at(input logic [7:0] a);
      wr_at = wr_take && (req.addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   logic        pready_r,  pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r,  prdata_nxt;
   logic        toggle_r,  toggle_nxt;
   logic        clear_r,   clear_nxt;
   logic        trn_en_r,  trn_en_nxt;
   logic [15:0] trn_set_r, trn_set_nxt;
   logic [15:0] trn_run_r, trn_run_nxt;
   logic [15:0] int_en_r,  int_en_nxt;
   logic [7:0]  stat_r,    stat_nxt;
   logic [7:0]  src_r,     src_nxt;
   logic        irq_r,     irq_nxt;
   logic [15:0] trn_view;

   // Running count is only visible while counting is enabled
   assign trn_view = trn_en_r ? trn_run_r : trn_set_r; // [R9]

   always_comb
   begin
      pready_nxt  = setup & ~pready_r;
      pslverr_nxt = setup & ~pready_r & ~hit(req.addr);
      prdata_nxt  = 32'h0000_0000;
      if (setup && !req.write)
      begin
         unique case (req.addr)
            `OFS_ENG_CTRL:  prdata_nxt[`BIT_ENG_BUSY] = I_ENG_BUSY;
            `OFS_DMA_CTRL:  prdata_nxt[`BIT_TRN_EN]   = trn_en_r;
            `OFS_TRN_CNT:   prdata_nxt[15:0]          = trn_view; // [R7] [R9]
            `OFS_INT_EN0:   prdata_nxt[15:0]          = int_en_r;
            `OFS_INT_STAT0: prdata_nxt[`IRQ_MSB:`IRQ_LSB] = stat_r;
            default:        prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_comb
   begin
      // Handover strobes; the busy check before writing is software's job
      toggle_nxt = wr_at(`OFS_ENG_CTRL) && req.wdata[`BIT_TOGGLE]
         && I_PIPE_RX; // [R1] [R3]
      clear_nxt  = wr_at(`OFS_ENG_CTRL) && req.wdata[`BIT_ENG_CLEAR]
         && !I_PIPE_RX; // [R4] [R6]
   end

   always_comb
   begin
      trn_en_nxt = trn_en_r;
      if (wr_at(`OFS_DMA_CTRL))
      begin
         trn_en_nxt = req.wdata[`BIT_TRN_EN];
      end
      trn_set_nxt = trn_set_r;
      trn_run_nxt = trn_run_r;
      if (wr_at(`OFS_TRN_CNT))
      begin
         // Reprogramming restarts the run; a step in the same cycle is dropped
         trn_set_nxt = req.wdata[15:0]; // [R7]
         trn_run_nxt = 16'h0000;
      end
      else if (I_TRN_STEP && I_PIPE_RX && trn_en_r)
      begin
         trn_run_nxt = trn_run_r + 16'h0001; // [R8]
      end
   end

   always_comb
   begin
      int_en_nxt = int_en_r;
      if (wr_at(`OFS_INT_EN0))
      begin
         int_en_nxt = req.wdata[15:0];
      end
      // Set wins over a write-one clear in the same cycle
      stat_nxt = stat_r;
      if (wr_at(`OFS_INT_STAT0))
      begin
         stat_nxt = stat_r & ~req.wdata[`IRQ_MSB:`IRQ_LSB];
      end
      stat_nxt = stat_nxt | I_IRQ_EVT;
      src_nxt  = stat_r & int_en_r[`IRQ_MSB:`IRQ_LSB]; // [R10] [R11] [R12] [R13] [R14] [R15]
      irq_nxt  = |src_nxt; // [R15]
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else
      begin
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         toggle_r  <= 1'b0;
         clear_r   <= 1'b0;
      end
      else
      begin
         toggle_r  <= toggle_nxt;
         clear_r   <= clear_nxt;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         trn_en_r  <= 1'b0;
         trn_set_r <= `RST_TRN_CNT;
         trn_run_r <= `RST_TRN_CNT;
      end
      else
      begin
         trn_en_r  <= trn_en_nxt;
         trn_set_r <= trn_set_nxt;
         trn_run_r <= trn_run_nxt;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         int_en_r  <= `RST_INT_EN0; // [R14]
         stat_r    <= 8'h00;
         src_r     <= 8'h00;
         irq_r     <= 1'b0;
      end
      else
      begin
         int_en_r  <= int_en_nxt;
         stat_r    <= stat_nxt;
         src_r     <= src_nxt;
         irq_r     <= irq_nxt;
      end
   end

   assign O_PREADY     = pready_r;
   assign O_PSLVERR    = pslverr_r;
   assign O_PRDATA     = prdata_r;
   assign O_BUF_TOGGLE = toggle_r;
   assign O_ENG_CLEAR  = clear_r;
   assign O_IRQ_SRC    = src_r;
   assign O_IRQ        = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_RST_B);

   sequence s_eng_wr;
      wr_take && req.addr == `OFS_ENG_CTRL;
   endsequence

   sequence s_setup_wait;
      setup && !O_PREADY;
   endsequence

   sequence s_stat_wr;
      wr_take && req.addr == `OFS_INT_STAT0 && I_IRQ_EVT == 8'h00;
   endsequence

   a_pready_answer: assert property ( // [R7]
      s_setup_wait |=> O_PREADY)
      else $error("Setup cycle got no ready in the next cycle");

   a_pready_pulse: assert property ( // [R7]
      O_PREADY |=> !O_PREADY)
      else $error("Ready stood longer than one cycle");

   a_err_with_ready: assert property ( // [R7]
      O_PSLVERR |-> O_PREADY)
      else $error("Error response without ready");

   a_rd_idle_zero: assert property ( // [R7]
      !O_PREADY |-> O_PRDATA == 32'h0000_0000)
      else $error("Read data not zero outside the answer cycle");

   a_toggle_pulse: assert property ( // [R1]
      O_BUF_TOGGLE |=> !O_BUF_TOGGLE)
      else $error("Toggle strobe longer than one cycle");

   a_clear_pulse: assert property ( // [R4]
      O_ENG_CLEAR |=> !O_ENG_CLEAR)
      else $error("Clear strobe longer than one cycle");

   a_handover_excl: assert property ( // [R3] [R6]
      !(O_BUF_TOGGLE && O_ENG_CLEAR))
      else $error("Toggle and clear strobes together");

   a_toggle_on_rx: assert property ( // [R1]
      s_eng_wr ##0 (req.wdata[`BIT_TOGGLE] && I_PIPE_RX) |=> O_BUF_TOGGLE)
      else $error("Toggle write on receive pipe gave no strobe");

   a_toggle_only_rx: assert property ( // [R3]
      O_BUF_TOGGLE |-> $past(I_PIPE_RX) && $past(wr_take))
      else $error("Toggle strobe without receive pipe write");

   a_clear_on_tx: assert property ( // [R4]
      s_eng_wr ##0 (req.wdata[`BIT_ENG_CLEAR] && !I_PIPE_RX) |=> O_ENG_CLEAR)
      else $error("Clear write on send pipe gave no strobe");

   a_clear_only_tx: assert property ( // [R6]
      O_ENG_CLEAR |-> !$past(I_PIPE_RX) && $past(wr_take))
      else $error("Clear strobe without send pipe write");

   a_trn_prog: assert property ( // [R7]
      wr_take && req.addr == `OFS_TRN_CNT |=> trn_set_r == $past(req.wdata[15:0])
         && trn_run_r == 16'h0000)
      else $error("Counter write did not program count");

   a_trn_step: assert property ( // [R8]
      !(wr_take && req.addr == `OFS_TRN_CNT) && I_TRN_STEP && I_PIPE_RX && trn_en_r
         |=> trn_run_r == $past(trn_run_r) + 16'h0001)
      else $error("Counter missed a transaction step");

   a_trn_idle_off: assert property ( // [R8]
      !trn_en_r && !wr_take |=> $stable(trn_run_r))
      else $error("Counter moved while counting disabled");

   a_trn_set_keep: assert property ( // [R9]
      !wr_take |=> $stable(trn_set_r))
      else $error("Programmed count changed without a write");

   a_trn_hold_tx: assert property ( // [R8]
      !I_PIPE_RX && !wr_take |=> $stable(trn_run_r))
      else $error("Counter moved outside receive direction");

   a_trn_view: assert property ( // [R9]
      setup && !req.write && req.addr == `OFS_TRN_CNT
         |=> O_PRDATA[15:0] == ($past(trn_en_r) ? $past(trn_run_r) : $past(trn_set_r)))
      else $error("Counter read returned wrong view");

   a_sof_gate: assert property ( // [R10]
      !int_en_r[13] |=> !O_IRQ_SRC[5])
      else $error("Frame refresh interrupt passed while disabled");

   a_dev_state_gate: assert property ( // [R11]
      !int_en_r[12] |=> !O_IRQ_SRC[4])
      else $error("Device state interrupt passed while disabled");

   a_ctrl_stage_gate: assert property ( // [R12]
      !int_en_r[11] |=> !O_IRQ_SRC[3])
      else $error("Control stage interrupt passed while disabled");

   a_not_ready_gate: assert property ( // [R13]
      !int_en_r[9] |=> !O_IRQ_SRC[1])
      else $error("Not-ready interrupt passed while disabled");

   a_en_write: assert property ( // [R14]
      wr_take && req.addr == `OFS_INT_EN0 |=> int_en_r == $past(req.wdata[15:0]))
      else $error("Interrupt enable write did not land");

   a_stat_set_wins: assert property ( // [R15]
      I_IRQ_EVT != 8'h00 |=> (stat_r & $past(I_IRQ_EVT)) == $past(I_IRQ_EVT))
      else $error("Event did not set its status bit");

   a_stat_w1c: assert property ( // [R15]
      s_stat_wr |=> (stat_r & $past(req.wdata[`IRQ_MSB:`IRQ_LSB])) == 8'h00)
      else $error("Write one did not clear status");

   a_src_gate: assert property ( // [R15]
      O_IRQ == (|O_IRQ_SRC))
      else $error("Interrupt output disagrees with sources");

   a_irq_follow: assert property ( // [R11] [R12] [R13] [R14]
      O_IRQ_SRC == $past(stat_r & int_en_r[`IRQ_MSB:`IRQ_LSB]))
      else $error("Gated source does not follow flag and enable");

endmodule
`default_nettype wire

// ===== tb/usb_sie_model.sv
// Behavioural model of the serial engine side facing the buffer block
`default_nettype none
module usb_sie_model
(
   input  wire logic       i_clk,
   input  wire logic       i_rx,
   input  wire logic       i_busy,
   input  wire logic       i_step,
   input  wire logic [7:0] i_evt,
   output logic            o_pipe_rx,
   output logic            o_eng_busy,
   output logic            o_trn_step,
   output logic      [7:0] o_irq_evt
);
   timeunit 1ns;
   timeprecision 1ns;
   // Registered so every change lands just after an edge, never on it
   always_ff @(posedge i_clk)
   begin
      o_pipe_rx  <= i_rx;
      o_eng_busy <= i_busy;
      o_trn_step <= i_step;
      o_irq_evt  <= i_evt;
   end
endmodule
`default_nettype wire

// ===== tb/test_usb_buffer_side_and_irq_enable.sv
// Self-checking bench for the buffer-side and interrupt-enable block
`default_nettype none
module test_usb_buffer_side_and_irq_enable;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]  paddr = 8'h00, evt = 8'h00, p_evt, irq_src;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        rx = 1'b0, busy = 1'b0, step = 1'b0, p_rx, p_busy, p_step;
   logic        pready, pslverr, err, tgl, clr, irq;
   int          bad_count = 0, n_checks = 0, n_tgl = 0, n_clr = 0;
   always #20 clk = ~clk;
   always @(posedge clk)
   begin
      if (tgl === 1'b1) n_tgl++;
      if (clr === 1'b1) n_clr++;
   end
   usb_sie_model SIE (.i_clk(clk), .i_rx(rx), .i_busy(busy), .i_step(step), .i_evt(evt),
      .o_pipe_rx(p_rx), .o_eng_busy(p_busy), .o_trn_step(p_step), .o_irq_evt(p_evt));
   usb_bufside_regs DUT (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PIPE_RX(p_rx),
      .I_ENG_BUSY(p_busy), .I_TRN_STEP(p_step), .I_IRQ_EVT(p_evt), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_PRDATA(prdata), .O_BUF_TOGGLE(tgl), .O_ENG_CLEAR(clr),
      .O_IRQ_SRC(irq_src), .O_IRQ(irq));
   ////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Waits on pready with a bound; a hung slave ends the run
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwr <= w;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 16)
      begin
         bad_count++;
         print_verdict();
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic pulse(input logic s, input logic [7:0] e);
      @(posedge clk);
      step <= s;
      evt <= e;
      @(posedge clk);
      step <= 1'b0;
      evt <= 8'h00;
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      apb(8'h30, 1'b0, 32'h0); chk(q, 32'h0);
      apb(8'h08, 1'b0, 32'h0); chk(q, 32'h0);
      apb(8'hF0, 1'b1, 32'hFFFF); chk({31'h0, err}, 32'h1);
      $display("register test done");
      apb(8'h30, 1'b1, 32'hFFFF); apb(8'h30, 1'b0, 32'h0); chk(q, 32'hFFFF);
      for (int n = 0; n < 8; n++)
      begin
         apb(8'h30, 1'b1, 32'h0100 << n);
         pulse(1'b0, 8'hFF);
         repeat (5) @(posedge clk);
         chk({23'h0, irq, irq_src}, {23'h0, 1'b1, 8'h01 << n});
         apb(8'h34, 1'b1, 32'hFF00);
         repeat (4) @(posedge clk);
         chk({31'h0, irq}, 32'h0);
      end
      apb(8'h30, 1'b1, 32'h0);
      pulse(1'b0, 8'hFF);
      repeat (5) @(posedge clk);
      chk({23'h0, irq, irq_src}, 32'h0);
      apb(8'h34, 1'b1, 32'hFF00);
      $display("interrupt test done");
      rx <= 1'b1;
      busy <= 1'b1;
      apb(8'h00, 1'b0, 32'h0); chk(q, 32'h2000);
      busy <= 1'b0;
      apb(8'h00, 1'b0, 32'h0); chk(q, 32'h0);
      apb(8'h00, 1'b1, 32'h8000);
      rx <= 1'b0;
      apb(8'h00, 1'b1, 32'h8000);
      apb(8'h00, 1'b1, 32'h4000);
      rx <= 1'b1;
      apb(8'h00, 1'b1, 32'h4000);
      repeat (3) @(posedge clk);
      chk(32'(n_tgl), 32'h1);
      chk(32'(n_clr), 32'h1);
      $display("handover test done");
      apb(8'h08, 1'b1, 32'h5); apb(8'h08, 1'b0, 32'h0); chk(q, 32'h5);
      apb(8'h04, 1'b1, 32'h1);
      repeat (3) pulse(1'b1, 8'h00);
      apb(8'h08, 1'b0, 32'h0); chk(q, 32'h3);
      rx <= 1'b0;
      repeat (2) pulse(1'b1, 8'h00);
      apb(8'h08, 1'b0, 32'h0); chk(q, 32'h3);
      apb(8'h04, 1'b1, 32'h0);
      apb(8'h08, 1'b0, 32'h0); chk(q, 32'h5);
      $display("counter test done");
      print_verdict();
   end
endmodule
`default_nettype wire
